// *** pbmc_mac_model.sv ***
// Far side model: MAC transmit stream, line receive stream and negotiation engine.
`timescale 1ns/100ps
`default_nettype none

module pbmc_mac_model (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Engine handshake
  input wire logic slow,
  input wire logic restart_req,
  output logic initiated,
  // Streams
  output logic [3:0] txd,
  output logic tx_en,
  output logic [3:0] line_rxd,
  output logic line_rx_dv
);
  // Stream data changes every cycle so a stuck path never matches by chance.
  logic [3:0] ph_reg;
  logic [3:0] wait_reg;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ph_reg <= 4'h0;
      wait_reg <= 4'h0;
      initiated <= 1'b0;
    end else begin
      ph_reg <= ph_reg + 4'h1;
      initiated <= 1'b0;
      wait_reg <= 4'h0;
      if (restart_req && !initiated) begin
        wait_reg <= wait_reg + 4'h1;
        initiated <= wait_reg == (slow ? 4'hc : 4'h1);
      end
    end
  end
  assign txd = ph_reg;
  assign tx_en = ph_reg[1];
  assign line_rxd = ~ph_reg;
  assign line_rx_dv = ph_reg[2];
endmodule

`default_nettype wire

// *** pbmc_mii_path.sv ***
// MII data steering: loopback, isolation and quieting of the receive and transmit paths.
`timescale 1ns/100ps
`default_nettype none

module pbmc_mii_path (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Mode controls
  input wire logic loopback,
  input wire logic quiet,
  // MAC side
  input wire logic [3:0] mii_txd,
  input wire logic mii_tx_en,
  output logic [3:0] mii_rxd,
  output logic mii_rx_dv,
  output logic mii_rx_oe,
  // Line side
  input wire logic [3:0] line_rxd,
  input wire logic line_rx_dv,
  output logic [3:0] line_txd,
  output logic line_tx_en
);

  typedef struct packed {
    logic [3:0] rxd;
    logic rx_dv;
    logic rx_oe;
    logic [3:0] txd;
    logic tx_en;
  } pbmc_path_t;

  pbmc_path_t r;
  pbmc_path_t n;

  always_comb begin
    n = r;
    if (quiet) begin
      // Receive pins float and nothing reaches the line.
      n.rxd = 4'h0; // [R11] [R08]
      n.rx_dv = 1'b0;
      n.rx_oe = 1'b0;
      n.txd = 4'h0;
      n.tx_en = 1'b0;
    end else if (loopback) begin
      // The line stays silent so looped frames never leave the port.
      n.rxd = mii_txd; // [R03]
      n.rx_dv = mii_tx_en; // [R03]
      n.rx_oe = 1'b1;
      n.txd = 4'h0;
      n.tx_en = 1'b0;
    end else begin
      n.rxd = line_rxd;
      n.rx_dv = line_rx_dv;
      n.rx_oe = 1'b1;
      n.txd = mii_txd;
      n.tx_en = mii_tx_en;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      r <= '{rxd: 4'h0, rx_dv: 1'b0, rx_oe: 1'b0, txd: 4'h0, tx_en: 1'b0};
    end else begin
      r <= n;
    end
  end

  assign mii_rxd = r.rxd;
  assign mii_rx_dv = r.rx_dv;
  assign mii_rx_oe = r.rx_oe;
  assign line_txd = r.txd;
  assign line_tx_en = r.tx_en;

endmodule

`default_nettype wire

// *** pbmc_params.svh ***
// Constants for the basic mode control register block: offsets, fields, defaults, timing.
//
// Contract
// R01 - Writing one to the reset bit starts a soft reset; bit reads one meanwhile.
// R02 - At soft reset end the reset bit clears itself and straps relatch.
// R03 - Loopback set routes MAC transmit data back to the MII receive outputs.
// R04 - Auto-negotiation off: speed bit one means 100 Mb/s, zero 10 Mb/s.
// R05 - Auto-negotiation on: speed and duplex bits are ignored for the operating mode.
// R06 - Auto-negotiation off: speed and duplex come straight from their bits.
// R07 - Auto-negotiation enable takes its reset value from its strap input.
// R08 - Power down bit set powers down the port; registers stay reachable.
// R09 - Power down is the OR of the power down bit and the pin.
// R10 - Pin low sets the power down bit.
// R11 - Isolate set disconnects the port from the MII; management still works.
// R12 - Writing one to the restart bit restarts auto-negotiation from the beginning.
// R13 - A restart write is ignored while auto-negotiation is disabled.
// R14 - Restart bit reads one until negotiation starts, then clears itself.
// R15 - Writing zero to restart never disturbs a negotiation already running.
// R16 - Auto-negotiation off: duplex bit one is full duplex, zero half duplex.
// R17 - Strap-defaulted bits reload from the strap inputs after every reset; an armed override replaces them instead.
// R18 - Writing zero to reset or restart leaves that bit unchanged; the code clears restart when the write also clears aneg enable.
`ifndef PBMC_PARAMS_SVH
`define PBMC_PARAMS_SVH

// Register addresses on the management port.
`define PBMC_ADDR_CONTROL 5'h00
`define PBMC_ADDR_STATUS 5'h11
`define PBMC_ADDR_STRAP 5'h12

// Field positions in the control register, plus the strap override enable at 15; the strap register reuses 13, 12 and 8.
`define PBMC_BIT_RESET 15
`define PBMC_BIT_LOOPBACK 14
`define PBMC_BIT_SPEED 13
`define PBMC_BIT_ANEG_EN 12
`define PBMC_BIT_POWER_DOWN 11
`define PBMC_BIT_ISOLATE 10
`define PBMC_BIT_RESTART 9
`define PBMC_BIT_DUPLEX 8
`define PBMC_BIT_STRAP_OVR 15

// Reset values of the strap-defaulted bits before the straps are caught.
`define PBMC_RST_SPEED 1'b1
`define PBMC_RST_ANEG_EN 1'b1
`define PBMC_RST_DUPLEX 1'b1

// Timing.
`define PBMC_CLK_PERIOD_NS 10
`define PBMC_SRST_TIME_NS 1000
`define PBMC_SRST_CYCLES ((`PBMC_SRST_TIME_NS + `PBMC_CLK_PERIOD_NS - 1) / `PBMC_CLK_PERIOD_NS)
`define PBMC_STRAP_SETTLE 3

`endif

// *** pbmc_pkg.sv ***
// Types shared by the basic mode control register block.
package pbmc_pkg;

  typedef enum logic [1:0] {
    PBMC_ST_STRAP = 2'b00,
    PBMC_ST_RUN = 2'b01,
    PBMC_ST_SRST = 2'b10
  } pbmc_state_t;

  typedef struct packed {
    logic loopback;
    logic speed_100;
    logic aneg_en;
    logic power_down;
    logic isolate;
    logic restart;
    logic full_duplex;
  } pbmc_ctl_t;

  typedef struct packed {
    logic enable;
    logic speed_100;
    logic aneg_en;
    logic full_duplex;
  } pbmc_strap_t;

endpackage

// *** pbmc_top.sv ***
// Basic mode control register with soft reset, strap relatch, power down and MII steering.
`timescale 1ns/100ps
`default_nettype none

`include "pbmc_params.svh"

module pbmc_top
  import pbmc_pkg::*;
#(
  parameter int SRST_CYCLES = `PBMC_SRST_CYCLES,
  parameter int CNT_W = 16
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,

  // Register port
  input wire logic [4:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,

  // Strap and power-down pins
  input wire logic strap_speed_100,
  input wire logic strap_aneg_en,
  input wire logic strap_full_duplex,
  input wire logic interrupt_powerdown_pin_n,

  // Auto-negotiation engine
  input wire logic aneg_initiated,
  input wire logic aneg_speed_100,
  input wire logic aneg_full_duplex,
  output logic aneg_restart_req,

  // Operating mode
  output logic soft_reset_active,
  output logic mode_speed_100,
  output logic mode_full_duplex,
  output logic mode_aneg_en,
  output logic mode_power_down,
  output logic mode_isolate,
  output logic mode_loopback,

  // MAC side of the MII
  input wire logic [3:0] mii_txd,
  input wire logic mii_tx_en,
  output logic [3:0] mii_rxd,
  output logic mii_rx_dv,
  output logic mii_rx_oe,

  // Line side of the port
  input wire logic [3:0] line_rxd,
  input wire logic line_rx_dv,
  output logic [3:0] line_txd,
  output logic line_tx_en
);

  ////////////////////////////////////////////////////////////////////////////////
  // State

  typedef struct packed {
    pbmc_state_t state;
    logic [CNT_W-1:0] cnt;
    pbmc_ctl_t ctl;
    pbmc_strap_t ovr;
    logic pd_meta;
    logic pd_sync;
    logic [2:0] strap_meta;
    logic [2:0] strap_sync;
    logic [15:0] rdata;
    logic out_srst;
    logic out_restart;
    logic out_speed;
    logic out_duplex;
    logic out_aneg;
    logic out_pd;
    logic out_iso;
    logic out_loop;
  } pbmc_top_t;

  pbmc_top_t r;
  pbmc_top_t n;

  logic wr_ctl;
  logic wr_strap;
  logic pin_pd;
  logic quiet;

  localparam logic [CNT_W-1:0] SRST_LOAD = CNT_W'(SRST_CYCLES - 1);
  localparam logic [CNT_W-1:0] SETTLE_LOAD = CNT_W'(`PBMC_STRAP_SETTLE);

  assign wr_ctl = reg_wr && (reg_addr == `PBMC_ADDR_CONTROL);
  assign wr_strap = reg_wr && (reg_addr == `PBMC_ADDR_STRAP);
  assign pin_pd = ~r.pd_sync;

  ////////////////////////////////////////////////////////////////////////////////
  // Defaults after any reset

  // Strap-defaulted bits take the software override when it is armed, else the
  // synchronised pins; everything else returns to normal operation.
  function automatic pbmc_ctl_t load_defaults(input logic [2:0] pins, input pbmc_strap_t ovr);
    pbmc_ctl_t c;
    c.loopback = 1'b0;
    c.power_down = 1'b0;
    c.isolate = 1'b0;
    c.restart = 1'b0;
    if (ovr.enable) begin
      c.speed_100 = ovr.speed_100;
      c.aneg_en = ovr.aneg_en;
      c.full_duplex = ovr.full_duplex;
    end else begin
      c.speed_100 = pins[2];
      c.aneg_en = pins[1]; // [R07]
      c.full_duplex = pins[0];
    end
    return c;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    n = r;

    // Pins from outside pass two flip-flops before anything looks at them.
    n.pd_meta = interrupt_powerdown_pin_n;
    n.pd_sync = r.pd_meta;
    n.strap_meta = {strap_speed_100, strap_aneg_en, strap_full_duplex};
    n.strap_sync = r.strap_meta;

    // The engine acknowledging the start clears a pending restart; a new request
    // in the same cycle is applied afterwards and therefore wins.
    n.ctl.restart = r.ctl.restart & ~aneg_initiated; // [R14]

    // The override register stays writable in every state so it can be armed
    // before a soft reset that should pick it up.
    if (wr_strap) begin
      n.ovr.enable = reg_wdata[`PBMC_BIT_STRAP_OVR];
      n.ovr.speed_100 = reg_wdata[`PBMC_BIT_SPEED];
      n.ovr.aneg_en = reg_wdata[`PBMC_BIT_ANEG_EN];
      n.ovr.full_duplex = reg_wdata[`PBMC_BIT_DUPLEX];
    end

    case (r.state)
      PBMC_ST_STRAP: begin
        // Wait for the strap synchronisers to fill before catching them.
        if (r.cnt == '0) begin
          n.ctl = load_defaults(r.strap_sync, r.ovr); // [R07] [R17]
          n.state = PBMC_ST_RUN;
        end else begin
          n.cnt = r.cnt - CNT_W'(1);
        end
      end
      PBMC_ST_RUN: begin
        if (wr_ctl) begin
          if (reg_wdata[`PBMC_BIT_RESET]) begin
            // Reset dominates: the other bits of this write are dropped.
            n.state = PBMC_ST_SRST; // [R01]
            n.cnt = SRST_LOAD;
          end else begin
            n.ctl.loopback = reg_wdata[`PBMC_BIT_LOOPBACK];
            n.ctl.speed_100 = reg_wdata[`PBMC_BIT_SPEED];
            n.ctl.aneg_en = reg_wdata[`PBMC_BIT_ANEG_EN];
            n.ctl.power_down = reg_wdata[`PBMC_BIT_POWER_DOWN];
            n.ctl.isolate = reg_wdata[`PBMC_BIT_ISOLATE];
            n.ctl.full_duplex = reg_wdata[`PBMC_BIT_DUPLEX];
            // Zero leaves a pending restart alone unless enable is also written zero; one only counts with
            // negotiation enabled by this same write.
            if (reg_wdata[`PBMC_BIT_RESTART] && reg_wdata[`PBMC_BIT_ANEG_EN]) begin
              n.ctl.restart = 1'b1; // [R12] [R13] [R15] [R18]
            end
            if (!reg_wdata[`PBMC_BIT_ANEG_EN]) begin
              n.ctl.restart = 1'b0; // [R13]
            end
          end
        end
      end
      PBMC_ST_SRST: begin
        // Control register writes are ignored until the reset is over; the override register stays writable.
        if (r.cnt == '0) begin
          n.ctl = load_defaults(r.strap_sync, r.ovr); // [R02] [R17]
          n.state = PBMC_ST_RUN; // [R02]
        end else begin
          n.cnt = r.cnt - CNT_W'(1);
        end
      end
      default: begin
        n.state = PBMC_ST_STRAP;
        n.cnt = SETTLE_LOAD;
      end
    endcase

    // The pin sets the bit after every other update so it is never lost.
    if (pin_pd) begin
      n.ctl.power_down = 1'b1; // [R10]
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Read data, valid in the cycle after the strobe only

    n.rdata = 16'h0000;
    if (reg_rd) begin
      case (reg_addr)
        `PBMC_ADDR_CONTROL: begin
          n.rdata[`PBMC_BIT_RESET] = (r.state == PBMC_ST_SRST); // [R01]
          n.rdata[`PBMC_BIT_LOOPBACK] = r.ctl.loopback;
          n.rdata[`PBMC_BIT_SPEED] = r.ctl.speed_100;
          n.rdata[`PBMC_BIT_ANEG_EN] = r.ctl.aneg_en;
          n.rdata[`PBMC_BIT_POWER_DOWN] = r.ctl.power_down;
          n.rdata[`PBMC_BIT_ISOLATE] = r.ctl.isolate;
          n.rdata[`PBMC_BIT_RESTART] = r.ctl.restart; // [R14]
          n.rdata[`PBMC_BIT_DUPLEX] = r.ctl.full_duplex;
        end
        `PBMC_ADDR_STATUS: begin
          n.rdata[0] = r.out_speed;
          n.rdata[1] = r.out_duplex;
          n.rdata[2] = r.out_pd;
          n.rdata[3] = pin_pd;
          n.rdata[4] = r.out_iso;
          n.rdata[5] = r.out_loop;
          n.rdata[6] = r.out_srst;
          n.rdata[7] = (r.state == PBMC_ST_STRAP);
        end
        `PBMC_ADDR_STRAP: begin
          n.rdata[`PBMC_BIT_STRAP_OVR] = r.ovr.enable;
          n.rdata[`PBMC_BIT_SPEED] = r.ovr.speed_100;
          n.rdata[`PBMC_BIT_ANEG_EN] = r.ovr.aneg_en;
          n.rdata[`PBMC_BIT_DUPLEX] = r.ovr.full_duplex;
        end
        default: begin
          n.rdata = 16'h0000;
        end
      endcase
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Mode outputs follow the next register value so they match a read.

    n.out_srst = (n.state == PBMC_ST_SRST);
    n.out_aneg = n.ctl.aneg_en;
    n.out_loop = n.ctl.loopback;
    n.out_iso = n.ctl.isolate; // [R11]
    n.out_pd = n.ctl.power_down | pin_pd; // [R08] [R09]
    if (n.ctl.aneg_en) begin
      n.out_speed = aneg_speed_100; // [R05]
      n.out_duplex = aneg_full_duplex; // [R05]
    end else begin
      n.out_speed = n.ctl.speed_100; // [R04] [R06]
      n.out_duplex = n.ctl.full_duplex; // [R06] [R16]
    end
    // A powered-down port holds its restart until it wakes; the bit stays set.
    n.out_restart = n.ctl.restart & ~n.out_pd & (n.state == PBMC_ST_RUN); // [R12]
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Registers

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      r.state <= PBMC_ST_STRAP;
      r.cnt <= SETTLE_LOAD;
      r.ctl.loopback <= 1'b0;
      r.ctl.speed_100 <= `PBMC_RST_SPEED;
      r.ctl.aneg_en <= `PBMC_RST_ANEG_EN;
      r.ctl.power_down <= 1'b0;
      r.ctl.isolate <= 1'b0;
      r.ctl.restart <= 1'b0;
      r.ctl.full_duplex <= `PBMC_RST_DUPLEX;
      r.ovr <= '{enable: 1'b0, speed_100: 1'b0, aneg_en: 1'b0, full_duplex: 1'b0};
      r.pd_meta <= 1'b1;
      r.pd_sync <= 1'b1;
      r.strap_meta <= {`PBMC_RST_SPEED, `PBMC_RST_ANEG_EN, `PBMC_RST_DUPLEX};
      r.strap_sync <= {`PBMC_RST_SPEED, `PBMC_RST_ANEG_EN, `PBMC_RST_DUPLEX};
      r.rdata <= 16'h0000;
      r.out_srst <= 1'b0;
      r.out_restart <= 1'b0;
      r.out_speed <= 1'b0;
      r.out_duplex <= 1'b0;
      r.out_aneg <= 1'b0;
      r.out_pd <= 1'b0;
      r.out_iso <= 1'b0;
      r.out_loop <= 1'b0;
    end else begin
      r <= n;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign reg_rdata = r.rdata;
  assign soft_reset_active = r.out_srst;
  assign aneg_restart_req = r.out_restart;
  assign mode_speed_100 = r.out_speed;
  assign mode_full_duplex = r.out_duplex;
  assign mode_aneg_en = r.out_aneg;
  assign mode_power_down = r.out_pd;
  assign mode_isolate = r.out_iso;
  assign mode_loopback = r.out_loop;

  // The MII is also quiet during soft reset and strap loading, so a half
  // configured port never drives the MAC.
  assign quiet = r.out_iso | r.out_pd | r.out_srst | (r.state == PBMC_ST_STRAP);

  pbmc_mii_path u_mii_path (
    .clk(clk),
    .rst_n(rst_n),
    .loopback(r.out_loop),
    .quiet(quiet),
    .mii_txd(mii_txd),
    .mii_tx_en(mii_tx_en),
    .mii_rxd(mii_rxd),
    .mii_rx_dv(mii_rx_dv),
    .mii_rx_oe(mii_rx_oe),
    .line_rxd(line_rxd),
    .line_rx_dv(line_rx_dv),
    .line_txd(line_txd),
    .line_tx_en(line_tx_en)
  );

endmodule

`default_nettype wire

// *** pbmc_top_properties.sv ***
// Concurrent checks on the ports of the basic mode control register block.
`timescale 1ns/100ps
`default_nettype none

module pbmc_properties #(
  parameter int SRST_CYCLES = 100
) (
  // Clock, reset and register port
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [4:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  // Pins and negotiation engine
  input wire logic interrupt_powerdown_pin_n,
  input wire logic aneg_initiated,
  input wire logic aneg_speed_100,
  input wire logic aneg_full_duplex,
  input wire logic aneg_restart_req,
  // Operating mode
  input wire logic soft_reset_active,
  input wire logic mode_speed_100,
  input wire logic mode_full_duplex,
  input wire logic mode_aneg_en,
  input wire logic mode_power_down,
  input wire logic mode_isolate,
  input wire logic mode_loopback,
  // MII and line
  input wire logic [3:0] mii_txd,
  input wire logic mii_tx_en,
  input wire logic [3:0] mii_rxd,
  input wire logic mii_rx_dv,
  input wire logic mii_rx_oe,
  input wire logic line_tx_en
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  ////////////////////////////////////////////////////////////////////////////////
  // Writes are only trusted well after any reset or strap load has settled.
  logic [2:0] idle_reg;
  logic [15:0] srst_reg;
  logic wr0, wn, lb_on;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      idle_reg <= 3'h0;
      srst_reg <= 16'h0000;
    end else begin
      idle_reg <= soft_reset_active ? 3'h0 : idle_reg + {2'h0, idle_reg != 3'h7};
      srst_reg <= soft_reset_active ? srst_reg + 16'h0001 : 16'h0000;
    end
  end
  assign wr0 = idle_reg == 3'h7 && reg_wr && reg_addr == 5'h00;
  assign wn = wr0 && !reg_wdata[15];
  assign lb_on = mode_loopback && !mode_isolate && !mode_power_down && !soft_reset_active;

  sequence lb_s;
    lb_on [*2];
  endsequence
  sequence pin_low_s;
    (idle_reg == 3'h7 && !interrupt_powerdown_pin_n) [*4];
  endsequence
  sequence aneg_held_s;
    idle_reg == 3'h7 && mode_aneg_en ##1 mode_aneg_en && !soft_reset_active;
  endsequence

  ////////////////////////////////////////////////////////////////////////////////
  srst_start_a: assert property (wr0 && reg_wdata[15] |=> soft_reset_active)
    else $error("soft reset did not start");
  srst_len_a: assert property ($fell(soft_reset_active) |-> srst_reg == SRST_CYCLES)
    else $error("soft reset length wrong");
  loop_path_a: assert property (lb_s |-> mii_rx_oe && !line_tx_en &&
    mii_rxd == $past(mii_txd) && mii_rx_dv == $past(mii_tx_en))
    else $error("loopback data wrong");
  fixed_mode_a: assert property (wn && !reg_wdata[12] |=> !mode_aneg_en &&
    mode_speed_100 == $past(reg_wdata[13]) && mode_full_duplex == $past(reg_wdata[8]))
    else $error("fixed speed or duplex wrong");
  aneg_mode_a: assert property (aneg_held_s |-> mode_speed_100 == $past(aneg_speed_100) &&
    mode_full_duplex == $past(aneg_full_duplex))
    else $error("negotiated mode not used");
  quiet_port_a: assert property ((mode_power_down || mode_isolate) [*2] |->
    !mii_rx_oe && !line_tx_en)
    else $error("port not quiet");
  pin_down_a: assert property (pin_low_s |=> mode_power_down)
    else $error("pin did not power down");
  restart_set_a: assert property (wn && reg_wdata[12] && reg_wdata[9] && !reg_wdata[11] &&
    interrupt_powerdown_pin_n && !mode_power_down |=> aneg_restart_req)
    else $error("restart not requested");
  restart_ign_a: assert property (wn && reg_wdata[9] && !reg_wdata[12] && !aneg_restart_req
    |=> !aneg_restart_req)
    else $error("restart not ignored");
  restart_clr_a: assert property (aneg_restart_req && aneg_initiated && !reg_wr
    |=> !aneg_restart_req)
    else $error("restart did not clear");
endmodule

bind pbmc_top pbmc_properties #(.SRST_CYCLES(SRST_CYCLES)) chk_u (
  .clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .interrupt_powerdown_pin_n(interrupt_powerdown_pin_n), .aneg_initiated(aneg_initiated),
  .aneg_speed_100(aneg_speed_100), .aneg_full_duplex(aneg_full_duplex),
  .aneg_restart_req(aneg_restart_req), .soft_reset_active(soft_reset_active),
  .mode_speed_100(mode_speed_100), .mode_full_duplex(mode_full_duplex),
  .mode_aneg_en(mode_aneg_en), .mode_power_down(mode_power_down),
  .mode_isolate(mode_isolate), .mode_loopback(mode_loopback), .mii_txd(mii_txd),
  .mii_tx_en(mii_tx_en), .mii_rxd(mii_rxd), .mii_rx_dv(mii_rx_dv), .mii_rx_oe(mii_rx_oe),
  .line_tx_en(line_tx_en)
);

`default_nettype wire

// *** tb_pbmc_top.sv ***
// Self-checking bench for the basic mode control register block.
`timescale 1ns/100ps
`default_nettype none

module tb_pbmc_top;
  typedef struct packed {
    logic [15:0] w;
    logic [15:0] rd;
    logic [5:0] m;
  } pbmc_row_t;
  // Mode bits are {loopback, speed, aneg, power down, isolate, duplex}.
  pbmc_row_t rows [9] = '{'{16'h2100, 16'h2100, 6'h11}, '{16'h0000, 16'h0000, 6'h00},
    '{16'h2000, 16'h2000, 6'h10}, '{16'h0100, 16'h0100, 6'h01}, '{16'h00ff, 16'h0000, 6'h00},
    '{16'h3100, 16'h3100, 6'h08}, '{16'h4400, 16'h4400, 6'h22}, '{16'h4800, 16'h4800, 6'h24},
    '{16'h0000, 16'h0000, 6'h00}};
  logic clk, rst_n, reg_wr, reg_rd, strap_sp, strap_an, strap_dp, pin_n, slow;
  logic aneg_init, aneg_sp, aneg_dp, restart_req, srst, m_sp, m_dp, m_an, m_pd, m_iso, m_lb;
  logic tx_en, rx_dv, rx_oe, l_rx_dv, l_tx_en;
  logic [4:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata, d;
  logic [3:0] txd, rxd, l_rxd, l_txd, t;
  int err_total = 0;
  int n_tests = 0;

  pbmc_top #(.SRST_CYCLES(4)) dut_u (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .strap_speed_100(strap_sp), .strap_aneg_en(strap_an), .strap_full_duplex(strap_dp),
    .interrupt_powerdown_pin_n(pin_n), .aneg_initiated(aneg_init), .aneg_speed_100(aneg_sp),
    .aneg_full_duplex(aneg_dp), .aneg_restart_req(restart_req), .soft_reset_active(srst),
    .mode_speed_100(m_sp), .mode_full_duplex(m_dp), .mode_aneg_en(m_an),
    .mode_power_down(m_pd), .mode_isolate(m_iso), .mode_loopback(m_lb), .mii_txd(txd),
    .mii_tx_en(tx_en), .mii_rxd(rxd), .mii_rx_dv(rx_dv), .mii_rx_oe(rx_oe), .line_rxd(l_rxd),
    .line_rx_dv(l_rx_dv), .line_txd(l_txd), .line_tx_en(l_tx_en));
  pbmc_mac_model mac_u (.clk(clk), .rst_n(rst_n), .slow(slow), .restart_req(restart_req),
    .initiated(aneg_init), .txd(txd), .tx_en(tx_en), .line_rxd(l_rxd), .line_rx_dv(l_rx_dv));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [15:0] v);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    #1;
  endtask
  task automatic rdc(input logic [4:0] a, input logic [15:0] exp, input logic [15:0] mask);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata & mask, exp);
  endtask
  // Waits for the restart request (0) or the soft reset (1) to drop.
  task automatic wait_clear(input bit which);
    int k;
    for (k = 0; k < 40 && (which ? srst : restart_req) !== 1'b0; k++) begin
      @(posedge clk);
      #1;
    end
    if (k == 40) begin
      err_total++;
      $display("mismatch at %0t: got %h expected %h", $time, 1'b1, 1'b0);
      complete_run();
    end
  endtask
  task automatic hw_reset();
    rst_n <= 1'b0;
    repeat (12) @(posedge clk);
    chk(16'(rx_oe), 16'h0000);
    rst_n <= 1'b1;
    repeat (8) @(posedge clk);
    #1;
  endtask

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    {reg_wr, reg_rd, reg_addr, reg_wdata, aneg_sp, aneg_dp} <= '0;
    {strap_sp, strap_an, strap_dp, pin_n, slow} <= 5'b00111;
    hw_reset();
    rdc(5'h00, 16'h0100, 16'hffff);
    foreach (rows[i]) begin
      wr(5'h00, rows[i].w);
      rdc(5'h00, rows[i].rd, 16'hffff);
      chk(16'({m_lb, m_sp, m_an, m_pd, m_iso, m_dp}), 16'(rows[i].m));
    end
    // In normal operation both streams pass through with one cycle of delay.
    #1 t = txd;
    d = 16'(l_rxd);
    @(posedge clk);
    #1 chk(16'({l_txd, rxd}), {8'h00, t, d[3:0]});
    // Loopback echoes transmit one cycle later and keeps the line silent.
    wr(5'h00, 16'h4000);
    repeat (2) @(posedge clk);
    #1 t = txd;
    @(posedge clk);
    #1 chk(16'({rxd, rx_oe, l_tx_en}), 16'({t, 2'b10}));
    // The pin forces power down and wins over a software clear.
    @(posedge clk);
    pin_n <= 1'b0;
    repeat (6) @(posedge clk);
    #1 chk(16'({m_pd, rx_oe}), 16'h0002);
    wr(5'h00, 16'h0000);
    rdc(5'h00, 16'h0800, 16'hffff);
    rdc(5'h11, 16'h000c, 16'hffff);
    @(posedge clk);
    pin_n <= 1'b1;
    repeat (4) @(posedge clk);
    wr(5'h00, 16'h0000);
    rdc(5'h00, 16'h0000, 16'hffff);
    wr(5'h00, 16'h0200);
    rdc(5'h00, 16'h0000, 16'hffff);
    wr(5'h00, 16'h1200);
    chk(16'(restart_req), 16'h0001);
    rdc(5'h00, 16'h1200, 16'hffff);
    wr(5'h00, 16'h1000);
    chk(16'(restart_req), 16'h0001);
    wait_clear(1'b0);
    rdc(5'h00, 16'h1000, 16'hffff);
    @(posedge clk);
    slow <= 1'b0;
    wr(5'h00, 16'h1200);
    wait_clear(1'b0);
    // Soft reset relatches the new straps and ignores the other bits written with it.
    @(posedge clk);
    {strap_sp, strap_an, strap_dp} <= 3'b110;
    repeat (4) @(posedge clk);
    wr(5'h00, 16'hc000);
    chk(16'(srst), 16'h0001);
    rdc(5'h00, 16'h8000, 16'h8000);
    wait_clear(1'b1);
    repeat (8) @(posedge clk);
    rdc(5'h00, 16'h3000, 16'hffff);
    // With negotiation on, the engine's result decides the mode, not the bits.
    @(posedge clk);
    aneg_sp <= 1'b1;
    aneg_dp <= 1'b1;
    repeat (2) @(posedge clk);
    #1 chk(16'({m_sp, m_dp}), 16'h0003);
    rdc(5'h11, 16'h0003, 16'hffff);
    wr(5'h1f, 16'hffff);
    rdc(5'h1f, 16'h0000, 16'hffff);
    rdc(5'h00, 16'h3000, 16'hffff);
    @(posedge clk);
    hw_reset();
    rdc(5'h00, 16'h3000, 16'hffff);
    // An armed override replaces the pins at the next soft reset.
    wr(5'h12, 16'h8100);
    rdc(5'h12, 16'h8100, 16'hffff);
    wr(5'h00, 16'h8000);
    wait_clear(1'b1);
    rdc(5'h00, 16'h0100, 16'hffff);
    complete_run();
  end
endmodule

`default_nettype wire
